// file: hdl/cdp_pkg.sv
package cdp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CDP_ADDR_SYNC_CTRL = 8'h58;
  localparam logic [7:0] CDP_ADDR_RSVD_SLOT = 8'h59;
  localparam logic [7:0] CDP_ADDR_TRANSFER = 8'h5A;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CDP_BIT_SYNC_DET_EN = 0;
  localparam int CDP_BIT_SYNC_SEL = 1;
  localparam int CDP_BIT_SOFT_SYNC = 2;
  localparam int CDP_BIT_DIST_REF_PD = 3;
  localparam int CDP_BIT_SYNC_PD = 4;
  localparam int CDP_BIT_ROLE_LO = 5;
  localparam int CDP_BIT_UPDATE = 0;
  localparam logic [7:0] CDP_SYNC_CTRL_MASK = 8'h7F;
  localparam logic [7:0] CDP_SYNC_CTRL_RST = 8'h00;
  localparam logic [7:0] CDP_ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CDP_NUM_OUT = 8;
  localparam int CDP_NUM_DELAY = 2;

  // ----------------------------------------------------------------
  // Role of the multi-purpose control pin
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CDP_ROLE_RESET = 2'b00,
    CDP_ROLE_ALIGN = 2'b01,
    CDP_ROLE_TEST = 2'b10,
    CDP_ROLE_POWERDOWN = 2'b11
  } cdp_role_e;

endpackage

// file: hdl/cdp_pin_func.sv
module cdp_pin_func (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic func_pin,
  input wire cdp_pkg::cdp_role_e role,
  input wire logic soft_sync,
  output logic pin_role_reset,
  output logic pin_role_powerdown,
  output logic pin_role_align,
  output logic div_restart
);
  import cdp_pkg::*;

  typedef struct packed {
    logic hold;
    logic restart;
    logic rst_req;
    logic pd_req;
  } cdp_pf_s;

  cdp_pf_s st_ff;
  cdp_pf_s nxt_st;

  // ----------------------------------------------------------------
  // Pin role decode and align edge
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rst_req = (role == CDP_ROLE_RESET) && !func_pin;
    nxt_st.pd_req = (role == CDP_ROLE_POWERDOWN) && !func_pin;
    // Test code drives nothing: software must never select it
    // Soft bit high holds like a low pin
    nxt_st.hold = ((role == CDP_ROLE_ALIGN) && !func_pin) || soft_sync;
    // Release of the hold restarts all dividers at once
    nxt_st.restart = st_ff.hold && !nxt_st.hold;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_role_reset = st_ff.rst_req;
  assign pin_role_powerdown = st_ff.pd_req;
  assign pin_role_align = st_ff.hold;
  assign div_restart = st_ff.restart;

endmodule

// file: hdl/cdp_ctrl.sv
// Functional notes
// - Sync power-down bit gates sync detector, default 0
// - Two-bit field selects multi-purpose pin role
// - Update bit copies staged registers to active
// - Update bit clears itself after transfer
// - Bypassed divider is powered down
// - Unselected fine-delay block is powered down
// - PLL, outputs, distribution each power down; distribution also downs outputs
// - Power cycling a block keeps its settings
// - Soft sync bit acts as inverted pin
// - Distribution reference power-down bit, default 0
module cdp_ctrl #(
  parameter int NUM_OUT = cdp_pkg::CDP_NUM_OUT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  input wire logic func_pin,
  input wire logic pll_pd_req,
  input wire logic dist_pd_req,
  input wire logic [NUM_OUT-1:0] out_pd_req,
  input wire logic [NUM_OUT-1:0] div_bypass,
  input wire logic delay_output_a_sel,
  input wire logic delay_output_b_sel,
  output logic sync_det_en,
  output logic sync_det_pd,
  output logic sync_slow_sel,
  output logic dist_ref_pd,
  output logic pll_pd,
  output logic dist_pd,
  output logic [NUM_OUT-1:0] out_pd,
  output logic [NUM_OUT-1:0] div_pd,
  output logic delay_output_a_pd,
  output logic delay_output_b_pd,
  output logic chip_reset_req,
  output logic div_restart,
  output logic align_hold,
  output logic align_lost
);
  import cdp_pkg::*;

  typedef struct packed {
    logic [7:0] staged;
    logic [7:0] active;
    logic update;
    logic [7:0] rd_data;
    logic [NUM_OUT+1:0] pd_prev;
    logic lost;
    logic pll_pd;
    logic dist_pd;
    logic [NUM_OUT-1:0] out_pd;
    logic [NUM_OUT-1:0] div_pd;
    logic [1:0] dly_pd;
  } cdp_ctrl_s;

  cdp_ctrl_s st_ff;
  cdp_ctrl_s nxt_st;
  logic pin_pd;
  logic pin_rst;
  logic restart;
  logic hold;
  logic [NUM_OUT+1:0] pd_now;
  cdp_role_e role;
  logic wr_ctrl;
  logic wr_xfer;
  logic pd_rise;
  logic [NUM_OUT-1:0] out_req_all;
  logic [NUM_OUT-1:0] div_req_all;
  logic [1:0] dly_req_all;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // Role field sits in the active copy, so a new role waits for update
  function automatic cdp_role_e role_of(input logic [7:0] ctrl);
    return cdp_role_e'(ctrl[CDP_BIT_ROLE_LO +: 2]);
  endfunction

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  // Reads return the staged byte, so software sees what it wrote even
  // before an update; reserved places always read back as zero.
  function automatic logic [7:0] read_value(
    input logic [7:0] a,
    input logic [7:0] staged,
    input logic upd
  );
    logic [7:0] v;
    v = CDP_ZERO_BYTE;
    if (hit(a, CDP_ADDR_SYNC_CTRL)) begin
      v = staged;
    end else if (hit(a, CDP_ADDR_TRANSFER)) begin
      v = {7'h00, upd};
    end else if (hit(a, CDP_ADDR_RSVD_SLOT)) begin
      v = CDP_ZERO_BYTE;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Multi-purpose pin and soft sync
  // ----------------------------------------------------------------
  assign role = role_of(st_ff.active);

  cdp_pin_func u_pin_func (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .func_pin(func_pin),
    .role(role),
    .soft_sync(st_ff.active[CDP_BIT_SOFT_SYNC]),
    .pin_role_reset(pin_rst),
    .pin_role_powerdown(pin_pd),
    .pin_role_align(hold),
    .div_restart(restart)
  );

  // Power-down is applied from a flop so a glitching request
  // cannot flicker the analog enables within one cycle.
  assign pd_now = {st_ff.pll_pd, st_ff.dist_pd, st_ff.out_pd};

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Writes only touch the staged copy; nothing moves until update
  assign wr_ctrl = reg_wr_en && hit(reg_addr, CDP_ADDR_SYNC_CTRL);
  assign wr_xfer = reg_wr_en && hit(reg_addr, CDP_ADDR_TRANSFER);

  // ----------------------------------------------------------------
  // Power-down fan-out
  // ----------------------------------------------------------------
  // Pin power-down overrides every local request
  assign out_req_all = out_pd_req | {NUM_OUT{dist_pd_req || pin_pd}};
  assign div_req_all = div_bypass | {NUM_OUT{pin_pd}};
  assign dly_req_all = ~{delay_output_b_sel, delay_output_a_sel}
                       | {2{pin_pd}};
  // Only a rising power-down counts, so a block that stays down does
  // not keep re-flagging the loss after a resync.
  assign pd_rise = |(pd_now & ~st_ff.pd_prev);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.update = 1'b0;
    if (st_ff.update) begin
      nxt_st.active = st_ff.staged & CDP_SYNC_CTRL_MASK;
    end
    if (wr_ctrl) begin
      nxt_st.staged = reg_wr_data & CDP_SYNC_CTRL_MASK;
    end
    if (wr_xfer) begin
      nxt_st.update = reg_wr_data[CDP_BIT_UPDATE];
    end
    if (reg_rd_en) begin
      nxt_st.rd_data = read_value(reg_addr, st_ff.staged, st_ff.update);
    end
    // Each block has its own request; settings are untouched
    nxt_st.pll_pd = pll_pd_req || pin_pd;
    nxt_st.dist_pd = dist_pd_req || pin_pd;
    nxt_st.out_pd = out_req_all;
    nxt_st.div_pd = div_req_all;
    nxt_st.dly_pd = dly_req_all;
    nxt_st.pd_prev = pd_now;
    // A fresh PLL, distribution or output power-down loses divider alignment; set beats clear
    if (restart) begin
      nxt_st.lost = 1'b0;
    end
    if (pd_rise) begin
      nxt_st.lost = 1'b1;
    end
    // Reset role on the pin returns the control bytes to defaults
    if (pin_rst) begin
      nxt_st.staged = CDP_SYNC_CTRL_RST;
      nxt_st.active = CDP_SYNC_CTRL_RST;
      nxt_st.update = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rd_data = st_ff.rd_data;
  assign sync_det_en = st_ff.active[CDP_BIT_SYNC_DET_EN]
                       && !st_ff.active[CDP_BIT_SYNC_PD];
  assign sync_det_pd = st_ff.active[CDP_BIT_SYNC_PD];
  assign sync_slow_sel = st_ff.active[CDP_BIT_SYNC_SEL];
  assign dist_ref_pd = st_ff.active[CDP_BIT_DIST_REF_PD];
  assign pll_pd = st_ff.pll_pd;
  assign dist_pd = st_ff.dist_pd;
  // Safe versus full-off for emitter outputs is the caller's pick
  assign out_pd = st_ff.out_pd;
  assign div_pd = st_ff.div_pd;
  assign delay_output_a_pd = st_ff.dly_pd[0];
  assign delay_output_b_pd = st_ff.dly_pd[1];
  assign chip_reset_req = pin_rst;
  assign div_restart = restart;
  assign align_hold = hold;
  assign align_lost = st_ff.lost;

endmodule

// file: tb/cdp_ctrl_props.sv
module cdp_ctrl_props #(
  parameter int NUM_OUT = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic pll_pd_req,
  input wire logic dist_pd_req,
  input wire logic [NUM_OUT-1:0] div_bypass,
  input wire logic delay_output_a_sel,
  input wire logic sync_det_en,
  input wire logic sync_det_pd,
  input wire logic pll_pd,
  input wire logic dist_pd,
  input wire logic [NUM_OUT-1:0] div_pd,
  input wire logic delay_output_a_pd,
  input wire logic div_restart,
  input wire logic align_hold,
  input wire logic align_lost
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  bypass_div_pd_a: assert property (1'b1 |=>
    ($past(div_bypass) & ~div_pd) == '0) else $error("divider left on");
  delay_pd_a: assert property (!delay_output_a_sel |=>
    delay_output_a_pd) else $error("delay block left on");
  pll_pd_a: assert property (pll_pd_req |=> pll_pd)
    else $error("pll not powered down");
  dist_pd_a: assert property (dist_pd_req |=> dist_pd)
    else $error("distribution not powered down");
  sync_pd_a: assert property (sync_det_pd |-> !sync_det_en)
    else $error("sync detector on while powered down");
  restart_pulse_a: assert property (div_restart |=> !div_restart)
    else $error("restart longer than one cycle");
  release_restart_a: assert property ($fell(align_hold) |->
    div_restart) else $error("no restart on hold release");
  lost_flag_a: assert property ($rose(pll_pd) |=> align_lost)
    else $error("alignment loss not flagged");
endmodule

bind cdp_ctrl cdp_ctrl_props #(.NUM_OUT(NUM_OUT)) u_props (
  .sys_clk, .sys_rst, .pll_pd_req, .dist_pd_req, .div_bypass,
  .delay_output_a_sel, .sync_det_en, .sync_det_pd, .pll_pd, .dist_pd,
  .div_pd, .delay_output_a_pd, .div_restart, .align_hold, .align_lost
);

// file: tb/cdp_host.sv
module cdp_host (
  input wire logic sys_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end
  // Idle bus shows inverted last values so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr_en = w;
    reg_rd_en = !w;
    reg_addr = a;
    reg_wr_data = (w && a == 8'h58 && d[6:5] == 2'b10) ? d ^ 8'h20 : d;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask
endmodule

// file: tb/clock_dist_power_update_ctrl_bench.sv
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %h got %h", n, e, s); end end
module clock_dist_power_update_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cdp_pkg::*;
  logic sys_clk = 0, sys_rst = 1, func_pin = 1, pll_pd_req = 0;
  logic dist_pd_req = 0, delay_output_a_sel = 0, delay_output_b_sel = 0;
  logic [7:0] out_pd_req = 0, div_bypass = 0, reg_addr, reg_wr_data;
  logic [7:0] reg_rd_data, out_pd, div_pd, note;
  logic reg_wr_en, reg_rd_en, sync_det_en, sync_det_pd, sync_slow_sel;
  logic dist_ref_pd, pll_pd, dist_pd, delay_output_a_pd, delay_output_b_pd;
  logic chip_reset_req, div_restart, align_hold, align_lost;
  int n_mismatch = 0, n_compared = 0, seed = 57, i, r;
  logic [7:0] exp_q[$];
  cdp_ctrl u_cdp_ctrl (.*);
  cdp_host u_cdp_host (.sys_clk, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wr_data);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cdp_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_cdp_host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Read data checker
  // ----------------------------------------------------------------
  always @(posedge sys_clk) if (reg_rd_en === 1'b1) begin
    @(negedge sys_clk);
    note = exp_q.pop_front();
    `CHK("reg_rd_data", note, reg_rd_data)
  end
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    tick(3);
    sys_rst = 0;
    tick(1);
    rd(8'h58, 8'h00);
    rd(8'h5A, 8'h00);
    wr(8'h58, 8'hFF);
    rd(8'h58, 8'h7F);
    wr(8'h59, 8'hA5);
    rd(8'h59, 8'h00);
    wr(8'h5A, 8'hFE);
    tick(3);
    `CHK("dist_ref_pd", 1'b0, dist_ref_pd)
    wr(8'h58, 8'h38);
    `CHK("dist_ref_pd", 1'b0, dist_ref_pd)
    wr(8'h5A, 8'h01);
    tick(3);
    `CHK("dist_ref_pd", 1'b1, dist_ref_pd)
    `CHK("sync_det_pd", 1'b1, sync_det_pd)
    rd(8'h5A, 8'h00);
    func_pin = 0;
    tick(3);
    `CHK("align_hold", 1'b1, align_hold)
    func_pin = 1;
    for (i = 0; i < 8 && div_restart !== 1'b1; i++) tick(1);
    if (i == 8) begin
      n_mismatch++;
    end
    tick(1);
    `CHK("div_restart", 1'b0, div_restart)
    wr(8'h58, 8'h3C);
    wr(8'h5A, 8'h01);
    tick(3);
    `CHK("align_hold", 1'b1, align_hold)
    // Random power requests, with the pin idle in align role
    repeat (8) begin
      r = $random(seed);
      {pll_pd_req, dist_pd_req} = r[3:2];
      {delay_output_a_sel, delay_output_b_sel} = r[1:0];
      // Output requests stand for the safe shutdown only
      out_pd_req = r[11:4];
      div_bypass = r[19:12];
      tick(2);
      `CHK("pll_pd", pll_pd_req, pll_pd)
      `CHK("dist_pd", dist_pd_req, dist_pd)
      `CHK("out_pd", out_pd_req | {8{dist_pd_req}}, out_pd)
      `CHK("div_pd", div_bypass, div_pd)
      `CHK("delay_a_pd", ~delay_output_a_sel, delay_output_a_pd)
      `CHK("delay_b_pd", ~delay_output_b_sel, delay_output_b_pd)
    end
    rd(8'h58, 8'h3C);
    // Quiet the PLL, distribution and output requests, then resync by dropping the soft bit
    {pll_pd_req, dist_pd_req} = 2'h0;
    out_pd_req = 8'h00;
    tick(2);
    wr(8'h58, 8'h38);
    wr(8'h5A, 8'h01);
    tick(3);
    `CHK("align_lost", 1'b0, align_lost)
    pll_pd_req = 1'b1;
    tick(3);
    `CHK("align_lost", 1'b1, align_lost)
    pll_pd_req = 1'b0;
    wr(8'h58, 8'h23);
    wr(8'h5A, 8'h01);
    tick(3);
    `CHK("sync_det_en", 1'b1, sync_det_en)
    `CHK("sync_slow_sel", 1'b1, sync_slow_sel)
    // Pin in power-down role
    wr(8'h58, 8'h60);
    wr(8'h5A, 8'h01);
    tick(3);
    func_pin = 0;
    tick(3);
    `CHK("pll_pd", 1'b1, pll_pd)
    `CHK("out_pd", 8'hFF, out_pd)
    `CHK("div_pd", 8'hFF, div_pd)
    `CHK("delay_b_pd", 1'b1, delay_output_b_pd)
    func_pin = 1;
    tick(3);
    `CHK("pll_pd", 1'b0, pll_pd)
    rd(8'h58, 8'h60);
    // Pin in reset role
    wr(8'h58, 8'h08);
    wr(8'h5A, 8'h01);
    tick(3);
    `CHK("dist_ref_pd", 1'b1, dist_ref_pd)
    func_pin = 0;
    tick(3);
    `CHK("chip_reset_req", 1'b1, chip_reset_req)
    `CHK("dist_ref_pd", 1'b0, dist_ref_pd)
    func_pin = 1;
    rd(8'h58, 8'h00);
    tick(2);
    close_out();
  end
endmodule
